/* smu_regs.svh */
// Offsets, field positions, reset values and descriptor count for the segment unit.
// Assumes inclusion by the package, the core and the test bench only; definitions only.
`ifndef SMU_REGS_SVH
`define SMU_REGS_SVH

// Command port register selects
`define SMU_REG_MODE      4'h0
`define SMU_REG_PTR       4'h1
`define SMU_REG_BYTECNT   4'h2
`define SMU_REG_CAUSE     4'h3
`define SMU_REG_FSEG      4'h4
`define SMU_REG_FOFF      4'h5
`define SMU_REG_ISEG      4'h6
`define SMU_REG_IOFF      4'h7
`define SMU_REG_BUSST     4'h8
`define SMU_REG_DESC      4'h9
`define SMU_REG_DESC_INC  4'hA

// Attribute byte bit positions
`define SMU_ATTR_RO       0
`define SMU_ATTR_PRIV     1
`define SMU_ATTR_CPUBLK   2
`define SMU_ATTR_FETCH    3
`define SMU_ATTR_DMABLK   4
`define SMU_ATTR_STACK    5
`define SMU_ATTR_WRITTEN  6
`define SMU_ATTR_ACCESSED 7

// Mode register bit positions
`define SMU_MODE_ID_LSB   0
`define SMU_MODE_ID_MSB   2
`define SMU_MODE_MST      3
`define SMU_MODE_NMS      4
`define SMU_MODE_URS      5
`define SMU_MODE_TRANSLATE_FLAG     6
`define SMU_MODE_UNIT_ENABLE_FLAG     7

// Violation cause bit positions
`define SMU_VC_WPROT      0
`define SMU_VC_PRIV       1
`define SMU_VC_CPUBLK     2
`define SMU_VC_FETCH      3
`define SMU_VC_BOUND      4
`define SMU_VC_WARN1      5
`define SMU_VC_WARN2      6
`define SMU_VC_FATAL      7

// Reset values
`define SMU_MODE_RST      8'h00
`define SMU_PTR_RST       6'h00
`define SMU_BYTECNT_RST   2'h0
`define SMU_CAUSE_RST     8'h00
`define SMU_STAT_RST      8'h00
`define SMU_ADDR_RST      16'h0000

// Descriptor count
`define SMU_NUM_DESC      64

`endif

/* smu_pkg.sv */
// Types shared by the segment unit core and whoever instantiates it.
// Assumes smu_regs.svh sits in the same folder.
package smu_pkg;
   `include "smu_regs.svh"

   typedef logic [7:0] smu_byte_t;
   typedef logic [5:0] smu_idx_t;
   typedef logic [6:0] smu_seg_t;
   typedef logic [3:0] smu_sel_t;

   // Which descriptor byte the byte counter points at
   typedef enum logic [1:0] {
      SMU_BASE_HI,
      SMU_BASE_LO,
      SMU_LIMIT,
      SMU_ATTR
   } smu_dbyte_e;
endpackage

/* smu_core.sv */
// Segment translation and protection unit: 64 descriptors, mode/pointer/counter, status capture.
// Assumes a command port already decoded from the CPU special I/O cycles, and memory
// requests presented as one-cycle strobes synchronous to ref_clk.
//
// Overview of operation
// R1 - Sixty-four descriptors; segment number of each request selects one.
// R2 - Descriptor holds base high, base low, limit and attribute bytes.
// R3 - Limit N gives N+1 blocks normally; stack segments span 64K-256N.
// R4 - Attribute bits 7..0: accessed, written, stack, DMA block, fetch, CPU block, priv, RO.
// R5 - Read-only segment: any write is a violation.
// R6 - Privileged-only segment: any Normal-mode access is a violation.
// R7 - Processor-block segment: CPU accesses violate, DMA accesses allowed.
// R8 - Fetch-only segment: only fetch or relative-addressing cycles allowed.
// R9 - DMA-block segment: DMA accesses violate, CPU accesses allowed.
// R10 - Stack segment write into final block raises trap without suppress.
// R11 - Clean writes set written flag; clean accesses set accessed flag.
// R12 - Mode register carries 3-bit unit number for trap acknowledge.
// R13 - Multi-table: translate only when normal/system input matches side select.
// R14 - Translate only when segment top bit equals upper-half select.
// R15 - Translate clear: pass segment and offset through unchecked, top bit zero.
// R16 - Unit enable clear keeps address outputs off the bus.
// R17 - Descriptor pointer picks one of 64, auto-increments for block access.
// R18 - Byte counter: 0 base high, 1 base low, 2 limit, 3 attribute.
// R19 - On violation capture fault address, last fetch address and bus status.
// R20 - Any CPU violation or warning raises trap and sets its cause flag; code traps only with no flags set and fatal clear, or on a first WARN2.
// R21 - Stack push warning with flags set sets second warning; later ones untrapped.
// R22 - Violation with flags set sets fatal; traps withheld, suppress kept.
// R23 - Physical upper address is base plus offset upper byte.
`timescale 1ns/100ps
`include "smu_regs.svh"

module smu_core
   import smu_pkg::*;
(
   input  wire logic               ref_clk,
   input  wire logic               rst_n,
   // Memory request, one-cycle strobe
   input  wire logic               req_valid,
   input  wire smu_pkg::smu_seg_t  req_seg,
   input  wire smu_pkg::smu_byte_t req_off_hi,
   input  wire logic               req_write,
   input  wire logic               req_normal,
   input  wire logic               req_dma,
   input  wire logic               req_fetch,
   input  wire logic [3:0]         req_status,
   // Trap acknowledge from the CPU side
   input  wire logic               trap_ack,
   // Command port
   input  wire logic               cmd_valid,
   input  wire logic               cmd_write,
   input  wire smu_pkg::smu_sel_t  cmd_sel,
   input  wire smu_pkg::smu_byte_t cmd_wdata,
   output logic     [7:0]          cmd_rdata,
   // Translated address and protection outputs
   output logic     [15:0]         addr_hi,
   output logic                    addr_oe_n,
   output logic                    suppress,
   output logic                    trap_req,
   output logic     [2:0]          unit_number
);
   import smu_pkg::*;

   // Descriptor storage
   smu_byte_t base_hi_mem [`SMU_NUM_DESC];
   smu_byte_t base_lo_mem [`SMU_NUM_DESC];
   smu_byte_t limit_mem   [`SMU_NUM_DESC];
   smu_byte_t attr_mem    [`SMU_NUM_DESC];

   smu_byte_t  unit_mode_control;
   smu_idx_t   descriptor_pointer;
   smu_dbyte_e descriptor_byte_counter;
   smu_byte_t  violation_cause;
   smu_byte_t  fault_segment_number;
   smu_byte_t  fault_offset;
   smu_byte_t  last_fetch_segment;
   smu_byte_t  last_fetch_offset;
   smu_byte_t  fault_bus_cycle_status;

   smu_idx_t   idx;
   smu_byte_t  attr;
   smu_byte_t  lim;
   logic       hit;
   logic       xlate;
   logic       v_wprot;
   logic       v_priv;
   logic       v_cpublk;
   logic       v_fetch;
   logic       v_dmablk;
   logic       v_bound;
   logic       viol;
   logic       warn;
   logic       cpu_ev;
   logic       flags_set;
   logic       push;
   logic [15:0] phys_hi;
   smu_byte_t  next_cause;
   logic       next_trap;
   logic       capture;
   logic       desc_acc;
   logic       cmd_wr;
   smu_byte_t  desc_rd;

   // Protection check for the request in flight
   always_comb begin
      // R1 descriptor select
      idx       = req_seg[5:0];
      // R4 attribute flag byte
      attr      = attr_mem[idx];
      lim       = limit_mem[idx];
      // R14 upper half match, R13 table side match, R16 enable
      hit       = unit_mode_control[`SMU_MODE_UNIT_ENABLE_FLAG]
                  && (req_seg[6] == unit_mode_control[`SMU_MODE_URS])
                  && (!unit_mode_control[`SMU_MODE_MST]
                      || (req_normal == unit_mode_control[`SMU_MODE_NMS]));
      // R15 checking only in translate mode
      xlate     = hit && unit_mode_control[`SMU_MODE_TRANSLATE_FLAG];
      // R5 write protect
      v_wprot   = attr[`SMU_ATTR_RO] && req_write;
      // R6 privileged only
      v_priv    = attr[`SMU_ATTR_PRIV] && req_normal;
      // R7 processor block
      v_cpublk  = attr[`SMU_ATTR_CPUBLK] && !req_dma;
      // R8 fetch only
      v_fetch   = attr[`SMU_ATTR_FETCH] && !req_fetch;
      // R9 DMA block
      v_dmablk  = attr[`SMU_ATTR_DMABLK] && req_dma;
      // R3 legal range, ascending or descending
      v_bound   = attr[`SMU_ATTR_STACK] ? (req_off_hi < lim) : (req_off_hi > lim);
      viol      = xlate && (v_wprot || v_priv || v_cpublk || v_fetch || v_dmablk
                            || v_bound);
      // R10 write into lowest allocated block of a stack segment
      warn      = xlate && !viol && attr[`SMU_ATTR_STACK] && req_write
                  && (req_off_hi == lim);
      cpu_ev    = req_valid && !req_dma;
      flags_set = |violation_cause[`SMU_VC_WARN1:`SMU_VC_WPROT];
      push      = !req_normal && req_write;
      // R23 base plus offset upper byte
      phys_hi   = {base_hi_mem[idx], base_lo_mem[idx]} + {8'h00, req_off_hi};
   end

   // Cause flags and trap decision; hardware sets beat software clears
   always_comb begin
      next_cause = violation_cause;
      next_trap  = trap_req && !trap_ack;
      capture    = 1'b0;
      if (cmd_wr && cmd_sel == `SMU_REG_CAUSE) begin
         next_cause = violation_cause & ~cmd_wdata;
      end
      if (cpu_ev && viol) begin
         // R20 cause flags and trap
         next_cause[`SMU_VC_WPROT]  = next_cause[`SMU_VC_WPROT] | v_wprot;
         next_cause[`SMU_VC_PRIV]   = next_cause[`SMU_VC_PRIV] | v_priv;
         next_cause[`SMU_VC_CPUBLK] = next_cause[`SMU_VC_CPUBLK] | v_cpublk;
         next_cause[`SMU_VC_FETCH]  = next_cause[`SMU_VC_FETCH] | v_fetch;
         next_cause[`SMU_VC_BOUND]  = next_cause[`SMU_VC_BOUND] | v_bound;
         capture = !flags_set;
         // R22 fatal on repeat violation, trap withheld
         if (flags_set) begin
            next_cause[`SMU_VC_FATAL] = 1'b1;
         end else if (!violation_cause[`SMU_VC_FATAL]) begin
            next_trap = 1'b1;
         end
      end else if (cpu_ev && warn) begin
         if (!flags_set) begin
            // R10 first warning traps
            next_cause[`SMU_VC_WARN1] = 1'b1;
            capture = 1'b1;
            next_trap = next_trap | !violation_cause[`SMU_VC_FATAL];
         end else if (push) begin
            // R21 second warning, trapped only once
            next_cause[`SMU_VC_WARN2] = 1'b1;
            next_trap = next_trap | (!violation_cause[`SMU_VC_WARN2]
                                     && !violation_cause[`SMU_VC_FATAL]);
         end else begin
            // R22 Normal-mode warning on top of flags is fatal
            next_cause[`SMU_VC_FATAL] = 1'b1;
         end
      end
   end

   assign cmd_wr   = cmd_valid && cmd_write;
   assign desc_acc = cmd_valid && (cmd_sel == `SMU_REG_DESC || cmd_sel == `SMU_REG_DESC_INC);

   // Cause register and trap line
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         violation_cause <= `SMU_CAUSE_RST;
         trap_req        <= 1'b0;
      end else begin
         violation_cause <= next_cause;
         trap_req        <= next_trap;
      end
   end

   // R19 status capture on first event; fetch address tracked until then
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_segment_number   <= `SMU_STAT_RST;
         fault_offset           <= `SMU_STAT_RST;
         last_fetch_segment     <= `SMU_STAT_RST;
         last_fetch_offset      <= `SMU_STAT_RST;
         fault_bus_cycle_status <= `SMU_STAT_RST;
      end else begin
         if (capture) begin
            fault_segment_number   <= {1'b0, req_seg};
            fault_offset           <= req_off_hi;
            fault_bus_cycle_status <= {2'b00, req_normal, !req_write, req_status};
         end
         if (cpu_ev && req_fetch && !flags_set && !(viol || warn)) begin
            last_fetch_segment <= {1'b0, req_seg};
            last_fetch_offset  <= req_off_hi;
         end
      end
   end

   // Address outputs; R16 unmatched or disabled unit releases the bus
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_hi   <= `SMU_ADDR_RST;
         addr_oe_n <= 1'b1;
         suppress  <= 1'b0;
      end else if (req_valid) begin
         addr_oe_n <= !hit;
         // R15 pass-through with top bit zero
         addr_hi   <= xlate ? phys_hi : {1'b0, req_seg, req_off_hi};
         // R10 warnings never suppress; R22 suppress survives fatal
         suppress  <= viol;
      end else begin
         suppress  <= 1'b0;
      end
   end

   // Mode register; R12 unit number straight from its field
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         unit_mode_control <= `SMU_MODE_RST;
         unit_number       <= 3'h0;
      end else if (cmd_wr && cmd_sel == `SMU_REG_MODE) begin
         unit_mode_control <= cmd_wdata;
         unit_number       <= cmd_wdata[`SMU_MODE_ID_MSB:`SMU_MODE_ID_LSB];
      end
   end

   // R17 pointer with auto-increment, R18 byte counter
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         descriptor_pointer      <= `SMU_PTR_RST;
         descriptor_byte_counter <= smu_dbyte_e'(`SMU_BYTECNT_RST);
      end else if (desc_acc) begin
         descriptor_byte_counter <= smu_dbyte_e'(descriptor_byte_counter + 2'h1);
         if (cmd_sel == `SMU_REG_DESC_INC && descriptor_byte_counter == SMU_ATTR) begin
            descriptor_pointer <= descriptor_pointer + 6'h01;
         end
      end else if (cmd_wr && cmd_sel == `SMU_REG_PTR) begin
         descriptor_pointer <= cmd_wdata[5:0];
      end else if (cmd_wr && cmd_sel == `SMU_REG_BYTECNT) begin
         descriptor_byte_counter <= smu_dbyte_e'(cmd_wdata[1:0]);
      end
   end

   // R2 descriptor byte writes; R11 usage flags set on clean access
   always_ff @(posedge ref_clk) begin
      if (cmd_wr && desc_acc) begin
         case (descriptor_byte_counter)
            SMU_BASE_HI: base_hi_mem[descriptor_pointer] <= cmd_wdata;
            SMU_BASE_LO: base_lo_mem[descriptor_pointer] <= cmd_wdata;
            SMU_LIMIT:   limit_mem[descriptor_pointer]   <= cmd_wdata;
            default:     attr_mem[descriptor_pointer]    <= cmd_wdata;
         endcase
      end
      // Hardware marking takes the later slot so it is never lost
      if (req_valid && xlate && !viol) begin
         attr_mem[idx][`SMU_ATTR_ACCESSED] <= 1'b1;
         if (req_write) begin
            attr_mem[idx][`SMU_ATTR_WRITTEN] <= 1'b1;
         end
      end
   end

   // Descriptor byte read mux
   always_comb begin
      case (descriptor_byte_counter)
         SMU_BASE_HI: desc_rd = base_hi_mem[descriptor_pointer];
         SMU_BASE_LO: desc_rd = base_lo_mem[descriptor_pointer];
         SMU_LIMIT:   desc_rd = limit_mem[descriptor_pointer];
         default:     desc_rd = attr_mem[descriptor_pointer];
      endcase
   end

   // Read data, one cycle after the command; unmapped selects read zero
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_rdata <= 8'h00;
      end else if (cmd_valid && !cmd_write) begin
         case (cmd_sel)
            `SMU_REG_MODE:     cmd_rdata <= unit_mode_control;
            `SMU_REG_PTR:      cmd_rdata <= {2'b00, descriptor_pointer};
            `SMU_REG_BYTECNT:  cmd_rdata <= {6'h00, descriptor_byte_counter};
            `SMU_REG_CAUSE:    cmd_rdata <= violation_cause;
            `SMU_REG_FSEG:     cmd_rdata <= fault_segment_number;
            `SMU_REG_FOFF:     cmd_rdata <= fault_offset;
            `SMU_REG_ISEG:     cmd_rdata <= last_fetch_segment;
            `SMU_REG_IOFF:     cmd_rdata <= last_fetch_offset;
            `SMU_REG_BUSST:    cmd_rdata <= fault_bus_cycle_status;
            `SMU_REG_DESC,
            `SMU_REG_DESC_INC: cmd_rdata <= desc_rd;
            default:           cmd_rdata <= 8'h00;
         endcase
      end
   end

   // Checks on the protection path
   sequence s_cpu_viol;
      req_valid && !req_dma && viol;
   endsequence

   sequence s_clean_write;
      req_valid && xlate && !viol && req_write;
   endsequence

   a_viol_suppress: assert property ( // R5
      @(posedge ref_clk) disable iff (!rst_n)
      (req_valid && viol) |=> suppress)
      else $error("violation not suppressed");

   a_warn_no_sup: assert property ( // R10
      @(posedge ref_clk) disable iff (!rst_n)
      (req_valid && warn && !req_dma && !flags_set && !violation_cause[`SMU_VC_FATAL])
      |=> (!suppress && trap_req && violation_cause[`SMU_VC_WARN1]))
      else $error("stack warning handled wrongly");

   a_bus_release: assert property ( // R16
      @(posedge ref_clk) disable iff (!rst_n)
      (req_valid && !hit) |=> addr_oe_n)
      else $error("address driven while unit not selected");

   a_pass_through: assert property ( // R15
      @(posedge ref_clk) disable iff (!rst_n)
      (req_valid && hit && !xlate) |=> (!addr_oe_n && !suppress
         && addr_hi == {1'b0, $past(req_seg), $past(req_off_hi)}))
      else $error("pass-through address wrong");

   a_translate_sum: assert property ( // R23
      @(posedge ref_clk) disable iff (!rst_n)
      (req_valid && xlate) |=> (addr_hi == $past(phys_hi)))
      else $error("translated address wrong");

   a_first_trap: assert property ( // R20
      @(posedge ref_clk) disable iff (!rst_n)
      (s_cpu_viol and (!flags_set && !violation_cause[`SMU_VC_FATAL]))
      |=> (trap_req && fault_segment_number == {1'b0, $past(req_seg)}
           && fault_offset == $past(req_off_hi)))
      else $error("first violation not trapped or captured");

   a_fatal_hold: assert property ( // R22
      @(posedge ref_clk) disable iff (!rst_n)
      (s_cpu_viol and flags_set) |=> (violation_cause[`SMU_VC_FATAL] && suppress))
      else $error("repeat violation not fatal");

   a_fatal_quiet: assert property ( // R22
      @(posedge ref_clk) disable iff (!rst_n)
      (violation_cause[`SMU_VC_FATAL] && !trap_req) |=> !trap_req)
      else $error("trap raised while fatal");

   a_dma_no_trap: assert property ( // R20
      @(posedge ref_clk) disable iff (!rst_n)
      (req_valid && req_dma && !trap_req) |=> !trap_req)
      else $error("DMA access raised a trap");

   a_written_mark: assert property ( // R11
      @(posedge ref_clk) disable iff (!rst_n)
      s_clean_write |=> attr_mem[$past(idx)][`SMU_ATTR_WRITTEN])
      else $error("written flag not set");

   a_ptr_advance: assert property ( // R17
      @(posedge ref_clk) disable iff (!rst_n)
      (cmd_valid && cmd_sel == `SMU_REG_DESC_INC && descriptor_byte_counter == SMU_ATTR)
      |=> (descriptor_pointer == $past(descriptor_pointer) + 6'h01
           && descriptor_byte_counter == SMU_BASE_HI))
      else $error("pointer did not advance at field end");
endmodule

/* smu_cpu_model.sv */
// Far-side CPU and DMA model: memory requests, command port, trap acknowledge.
// Assumes the unit samples on rising ref_clk; all lines move on falling edges.
`timescale 1ns/100ps

module smu_cpu_model
   import smu_pkg::*;
(
   input  wire logic         ref_clk,
   output logic              req_valid,
   output smu_pkg::smu_seg_t  req_seg,
   output smu_pkg::smu_byte_t req_off_hi,
   output logic              req_write,
   output logic              req_normal,
   output logic              req_dma,
   output logic              req_fetch,
   output logic [3:0]        req_status,
   output logic              trap_ack,
   output logic              cmd_valid,
   output logic              cmd_write,
   output smu_pkg::smu_sel_t  cmd_sel,
   output smu_pkg::smu_byte_t cmd_wdata
);
   // Idle bus values at time zero
   initial begin
      {req_valid, trap_ack, cmd_valid, cmd_write} = 4'h0;
      {req_seg, req_off_hi, req_status} = '0;
      {req_write, req_normal, req_dma, req_fetch} = 4'h0;
      {cmd_sel, cmd_wdata} = '0;
   end

   // One request; returns just after the answer edge so one-cycle outputs still stand
   task automatic access(input smu_seg_t s, input smu_byte_t o,
                         input logic [3:0] k, input logic [3:0] st);
      @(negedge ref_clk);
      {req_seg, req_off_hi, req_status} = {s, o, st};
      {req_write, req_normal, req_dma, req_fetch} = k;
      req_valid = 1'b1;
      @(negedge ref_clk);
      req_valid = 1'b0;
      // Released lines flip so stale values never look valid
      {req_seg, req_off_hi, req_status} = ~{s, o, st};
      {req_write, req_normal, req_dma, req_fetch} = ~k;
   endtask

   // One command byte; read data is settled on return
   task automatic command(input smu_sel_t s, input logic w, input smu_byte_t d);
      @(negedge ref_clk);
      {cmd_sel, cmd_write, cmd_wdata} = {s, w, d};
      cmd_valid = 1'b1;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      {cmd_sel, cmd_write, cmd_wdata} = ~{s, w, d};
      @(negedge ref_clk);
   endtask

   // Trap acknowledge pulse
   task automatic ack();
      @(negedge ref_clk);
      trap_ack = 1'b1;
      @(negedge ref_clk);
      trap_ack = 1'b0;
      @(negedge ref_clk);
   endtask
endmodule

/* smu_core_test.sv */
// Self-checking bench for smu_core: registers, translation, protection, warnings.
// Assumes smu_cpu_model drives every input of the unit except clock and reset.
`timescale 1ns/100ps
`include "smu_regs.svh"

module smu_core_test;
   import smu_pkg::*;
   logic        ref_clk, rst_n, req_valid, req_write, req_normal, req_dma;
   logic        req_fetch, trap_ack, cmd_valid, cmd_write;
   logic        addr_oe_n, suppress, trap_req;
   smu_seg_t    req_seg;
   smu_byte_t   req_off_hi, cmd_wdata, cmd_rdata;
   smu_sel_t    cmd_sel;
   logic [3:0]  req_status;
   logic [15:0] addr_hi;
   logic [2:0]  unit_number;
   int          bad_count = 0;
   int          total_checks = 0;
   // Access kind bits: write, normal, dma, fetch
   smu_seg_t    v_seg [7] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h00, 7'h06};
   smu_byte_t   v_off [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h7F};
   logic [3:0]  v_k [7] = '{4'h8, 4'h4, 4'h0, 4'h0, 4'h2, 4'h0, 4'h0};
   smu_byte_t   v_c [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h00, 8'h10, 8'h10};
   smu_byte_t   attr [7] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20};
   smu_byte_t   m_mode [6] = '{8'h80, 8'h00, 8'hC0, 8'hE0, 8'hC8, 8'hC8};
   smu_seg_t    m_seg [6] = '{7'h05, 7'h05, 7'h40, 7'h40, 7'h00, 7'h00};
   logic [3:0]  m_k [6] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'h0};
   logic [15:0] m_addr [6] = '{16'h050B, 16'h0, 16'h0, 16'h013F, 16'h0, 16'h013F};

   smu_core i_dut (.ref_clk, .rst_n, .req_valid, .req_seg, .req_off_hi, .req_write,
      .req_normal, .req_dma, .req_fetch, .req_status, .trap_ack, .cmd_valid,
      .cmd_write, .cmd_sel, .cmd_wdata, .cmd_rdata, .addr_hi, .addr_oe_n,
      .suppress, .trap_req, .unit_number);
   smu_cpu_model i_cpu (.ref_clk, .req_valid, .req_seg, .req_off_hi, .req_write,
      .req_normal, .req_dma, .req_fetch, .req_status, .trap_ack, .cmd_valid,
      .cmd_write, .cmd_sel, .cmd_wdata);

   // 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input smu_sel_t s, input smu_byte_t d);
      i_cpu.command(s, 1'b1, d);
   endtask
   task automatic rd(input smu_sel_t s, input smu_byte_t e);
      i_cpu.command(s, 1'b0, 8'h00);
      chk($sformatf("rdata_sel%h", s), {8'h00, e}, {8'h00, cmd_rdata});
   endtask
   task automatic rd_attr(input smu_byte_t p, input smu_byte_t e);
      wr(`SMU_REG_PTR, p);
      wr(`SMU_REG_BYTECNT, 8'h03);
      rd(`SMU_REG_DESC, e);
   endtask
   // Expected e is {addr_oe_n, suppress, trap_req}; address only when driven clean
   task automatic mem(input smu_seg_t s, input smu_byte_t o, input logic [3:0] k,
                      input logic [15:0] ea, input logic [2:0] e);
      i_cpu.access(s, o, k, 4'h9);
      chk("oe_sup_trap", {13'h0, e}, {13'h0, addr_oe_n, suppress, trap_req});
      if (e[2:1] == 2'b00) chk("addr_hi", ea, addr_hi);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Watchdog: the run needs a few hundred cycles, so this means a hang
   initial begin
      #200000;
      bad_count++;
      tally_and_finish();
   end

   initial begin
      rst_n = 1'b0;
      repeat (20) @(negedge ref_clk);
      chk("idle_out", 16'h0004, {13'h0, addr_oe_n, suppress, trap_req});
      rst_n = 1'b1;
      // Reset values, read-only status and unmapped select
      rd(`SMU_REG_MODE, 8'h00);
      rd(`SMU_REG_PTR, 8'h00);
      rd(`SMU_REG_CAUSE, 8'h00);
      wr(`SMU_REG_FSEG, 8'hFF);
      rd(`SMU_REG_FSEG, 8'h00);
      rd(4'hB, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 7; i++) begin
         wr(`SMU_REG_DESC_INC, 8'(i + 1));
         wr(`SMU_REG_DESC_INC, 8'h34);
         wr(`SMU_REG_DESC_INC, (i == 6) ? 8'h80 : 8'h10);
         wr(`SMU_REG_DESC_INC, attr[i]);
      end
      rd(`SMU_REG_PTR, 8'h07);
      rd(`SMU_REG_BYTECNT, 8'h00);
      wr(`SMU_REG_PTR, 8'h02);
      rd(`SMU_REG_DESC, 8'h03);
      rd(`SMU_REG_DESC, 8'h34);
      rd(`SMU_REG_DESC, 8'h10);
      rd(`SMU_REG_DESC, 8'h02);
      rd(`SMU_REG_PTR, 8'h02);
      $display("test descriptors done");
      for (int i = 0; i < 6; i++) begin
         wr(`SMU_REG_MODE, m_mode[i]);
         mem(m_seg[i], 8'h0B, m_k[i], m_addr[i], {m_addr[i] == 16'h0, 2'b00});
      end
      wr(`SMU_REG_MODE, 8'hC5);
      chk("unit_number", 16'h0005, {13'h0, unit_number});
      wr(`SMU_REG_MODE, 8'hC0);
      $display("test modes done");
      // clean accesses mark the attribute byte
      mem(7'h00, 8'h05, 4'h1, 16'h0139, 3'b000);
      mem(7'h00, 8'h10, 4'h8, 16'h0144, 3'b000);
      mem(7'h03, 8'h00, 4'h2, 16'h0434, 3'b000);
      rd_attr(8'h00, 8'hC0);
      rd_attr(8'h03, 8'h84);
      $display("test clean done");
      for (int i = 0; i < 7; i++) begin
         mem(v_seg[i], v_off[i], v_k[i], 16'h0, {2'b01, v_c[i] != 8'h00});
         rd(`SMU_REG_CAUSE, v_c[i]);
         if (v_c[i] != 8'h00) begin
            rd(`SMU_REG_FSEG, {1'b0, v_seg[i]});
            rd(`SMU_REG_FOFF, v_off[i]);
            rd(`SMU_REG_ISEG, 8'h00);
            rd(`SMU_REG_IOFF, 8'h05);
            rd(`SMU_REG_BUSST, {2'b00, v_k[i][2], ~v_k[i][3], 4'h9});
         end
         i_cpu.ack();
         chk("trap_clear", 16'h0, {15'h0, trap_req});
         wr(`SMU_REG_CAUSE, 8'hFF);
      end
      rd(`SMU_REG_CAUSE, 8'h00);
      $display("test violations done");
      mem(7'h06, 8'h80, 4'h8, 16'h07B4, 3'b001);
      rd(`SMU_REG_CAUSE, 8'h20);
      i_cpu.ack();
      mem(7'h06, 8'h80, 4'h8, 16'h07B4, 3'b001);
      rd(`SMU_REG_CAUSE, 8'h60);
      i_cpu.ack();
      mem(7'h06, 8'h80, 4'h8, 16'h07B4, 3'b000);
      mem(7'h01, 8'h00, 4'h8, 16'h0, 3'b010);
      i_cpu.command(`SMU_REG_CAUSE, 1'b0, 8'h00);
      chk("fatal", 16'h0080, {8'h00, cmd_rdata & 8'h80});
      mem(7'h02, 8'h00, 4'h4, 16'h0, 3'b010);
      $display("test warnings done");
      tally_and_finish();
   end
endmodule
